// ### rtl/fsp_pkg.sv
// constants and types shared by the self-programming sequencer and the core end
// assumes both ends run on one 100 MHz clock under one asynchronous reset
package fsp_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int MIN_CPU_MHZ = 1;
    localparam int HALT_MAX_US = 10;
    localparam int HALT_EXTRA_CLK = 2;
    localparam int HALT_REL_CYC = HALT_MAX_US * CLK_MHZ + HALT_EXTRA_CLK;
    localparam int OSC_WAIT_US = 8;
    localparam int OSC_WAIT_CYC = OSC_WAIT_US * CLK_MHZ;
    localparam int FLASH_READY_CYC = 64;
    localparam int CMD_BUSY_CYC = 16;
    // ==========================================================
    // data values
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // ==========================================================
    // commands
    typedef enum logic [1:0] {FSP_CMD_WRITE, FSP_CMD_ERASE, FSP_CMD_EXIT} fsp_cmd_t;
endpackage : fsp_pkg

// ### rtl/fsp_if.sv
// link between the processor core end and the flash self-programming sequencer
// assumes one clock domain; no tri-state signals
`timescale 1ns/100ps
interface fsp_if;
    logic enter_req;
    logic halt_req;
    logic halt_rel;
    logic cmd_valid;
    fsp_pkg::fsp_cmd_t cmd;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
    logic busy;
    logic done;
    logic mode_on;
    logic prot_err;
    logic bit_test;
    logic irq_raw;
    logic irq_ack;
    logic irq_mask_all;
    logic irq_di;
    modport seq (input enter_req, halt_req, cmd_valid, cmd, cmd_addr, cmd_data, bit_test, irq_raw,
        irq_mask_all, irq_di, output halt_rel, busy, done, mode_on, prot_err, irq_ack);
    modport core (output enter_req, halt_req, cmd_valid, cmd, cmd_addr, cmd_data, bit_test, irq_raw,
        irq_mask_all, irq_di, input halt_rel, busy, done, mode_on, prot_err, irq_ack);
endinterface : fsp_if

// ### rtl/fsp_core_end.sv
// core end: drives entry sequence, nop/halt, waits, commands, exit
// assumes user side issues one request at a time
`timescale 1ns/100ps
module fsp_core_end #(
    parameter int OSC_WAIT = fsp_pkg::OSC_WAIT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    fsp_if.core lnk,
    // user side
    input wire logic usr_enter,
    input wire logic usr_osc_clk,
    input wire logic usr_clk_ok,
    input wire logic usr_cmd_valid,
    input wire fsp_pkg::fsp_cmd_t usr_cmd,
    input wire logic [7:0] usr_addr,
    input wire logic [7:0] usr_data,
    input wire logic usr_irq,
    input wire logic usr_err_check,
    output logic usr_ready,
    output logic usr_in_mode,
    output logic usr_err_ff,
    output logic usr_irq_taken
);
    // ==========================================================
    // sequence state
    typedef enum logic [2:0] {C_IDLE, C_ENTER, C_HALT, C_WAIT, C_RUN, C_EXIT} fsp_cst_t;
    fsp_cst_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic err_ff, nxt_err;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_err = err_ff;
        unique case (st_ff)
            C_IDLE: if (usr_enter && usr_clk_ok) nxt_st = C_ENTER;
            C_ENTER: nxt_st = C_HALT;
            C_HALT: if (lnk.halt_rel) begin
                nxt_st = usr_osc_clk ? C_WAIT : C_RUN;
                nxt_cnt = 16'(OSC_WAIT);
            end
            C_WAIT: begin
                nxt_cnt = cnt_ff - 16'h0001;
                if (cnt_ff <= 16'h0001) nxt_st = C_RUN;
            end
            C_RUN: if (usr_cmd_valid && !lnk.busy && usr_cmd == fsp_pkg::FSP_CMD_EXIT) nxt_st = C_EXIT;
            C_EXIT: nxt_st = C_IDLE;
        endcase
        if (usr_err_check) nxt_err = lnk.prot_err;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= C_IDLE;
            cnt_ff <= 16'h0000;
            err_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            err_ff <= nxt_err;
        end
    end

    // ==========================================================
    // link drive
    // mask and di held from entry through exit so no interrupt is serviced mid-mode
    assign lnk.irq_mask_all = (st_ff != C_IDLE);
    assign lnk.irq_di = (st_ff != C_IDLE);
    assign lnk.enter_req = (st_ff == C_ENTER);
    assign lnk.halt_req = (st_ff == C_HALT);
    assign lnk.cmd_valid = (st_ff == C_RUN) && usr_cmd_valid && !lnk.busy;
    assign lnk.cmd = usr_cmd;
    assign lnk.cmd_addr = usr_addr;
    assign lnk.cmd_data = usr_data;
    assign lnk.bit_test = usr_err_check;
    assign lnk.irq_raw = usr_irq;
    assign usr_ready = (st_ff == C_RUN) && !lnk.busy;
    assign usr_in_mode = lnk.mode_on;
    assign usr_err_ff = err_ff;
    assign usr_irq_taken = lnk.irq_ack;
endmodule : fsp_core_end

// ### rtl/fsp_seq.sv
// self-programming sequencer: mode entry, halt release, flash commands, irq deferral
// assumes the core end keeps the clock floor, mask/di and the oscillator wait
// Functional notes
// - defer interrupts until self-programming mode exits
// - core masks all, disables interrupts first
// - no data ram access during commands
// - block erase leaves every byte ff
// - core keeps clock at least 1 MHz
// - nop, halt; released within 10us plus two
// - oscillator clock: wait 8us before commands
// - error flag read only by bit test
// - reset mid-write leaves area undefined
`timescale 1ns/100ps
module fsp_seq #(
    parameter int BLK_BYTES = 16,
    parameter int NBLK = 16,
    parameter int HALT_CYC = fsp_pkg::HALT_REL_CYC,
    parameter int READY_CYC = fsp_pkg::FLASH_READY_CYC,
    parameter int BUSY_CYC = fsp_pkg::CMD_BUSY_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    fsp_if.seq lnk,
    // user side: flash array view and ram guard
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_ff,
    output logic ram_en,
    output logic [7:0] cmd_fail_cnt_ff
);
    localparam int AW = $clog2(BLK_BYTES * NBLK);
    localparam int BW = $clog2(BLK_BYTES);
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] FAIL_MAX = 8'hff;

    // ==========================================================
    // mode and command state
    typedef enum logic [2:0] {S_NORM, S_ENT, S_HALT, S_MODE, S_BUSY} fsp_sst_t;
    fsp_sst_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic rel_ff, nxt_rel;
    logic perr_ff, nxt_perr;
    logic irq_pend_ff, nxt_irq_pend;
    logic ack_ff, nxt_ack;
    logic done_ff, nxt_done;
    fsp_pkg::fsp_cmd_t op_ff, nxt_op;
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] data_ff, nxt_data;
    logic [7:0] fail_ff, nxt_fail;
    logic [7:0] mem [BLK_BYTES * NBLK];

    function automatic logic in_mode(input fsp_sst_t s);
        in_mode = (s != S_NORM);
    endfunction : in_mode

    // last cycle of a down-count; shared by halt, busy and the array commit
    function automatic logic cnt_last(input logic [15:0] c);
        cnt_last = (c <= CNT_ONE);
    endfunction : cnt_last

    // refused requests saturate so a flood never wraps the count to zero
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == FAIL_MAX) ? v : v + 8'h01;
    endfunction : sat_inc

    // only write and erase start an array cycle
    function automatic logic is_array_op(input fsp_pkg::fsp_cmd_t c);
        is_array_op = (c == fsp_pkg::FSP_CMD_WRITE) || (c == fsp_pkg::FSP_CMD_ERASE);
    endfunction : is_array_op

    // block number of a byte address
    function automatic int blk_of(input int a);
        blk_of = a >> BW;
    endfunction : blk_of

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_rel = 1'b0;
        nxt_perr = perr_ff;
        nxt_done = 1'b0;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_fail = fail_ff;
        unique case (st_ff)
            S_NORM: begin
                if (lnk.enter_req) begin
                    // entry without mask-all and di counts as a protection fault
                    if (!(lnk.irq_mask_all && lnk.irq_di)) begin
                        nxt_perr = 1'b1;
                        nxt_fail = sat_inc(fail_ff);
                    end else begin
                        nxt_st = S_ENT;
                    end
                end
            end
            S_ENT: begin
                // flash may be ready before the worst case, so the shorter count wins
                if (lnk.halt_req) begin
                    nxt_st = S_HALT;
                    nxt_cnt = 16'(READY_CYC < HALT_CYC ? READY_CYC : HALT_CYC);
                end
            end
            S_HALT: begin
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_last(cnt_ff)) begin
                    nxt_rel = 1'b1;
                    nxt_st = S_MODE;
                end
            end
            S_MODE: begin
                if (lnk.cmd_valid) begin
                    if (lnk.cmd == fsp_pkg::FSP_CMD_EXIT) begin
                        nxt_st = S_NORM;
                    end else if (is_array_op(lnk.cmd)) begin
                        nxt_st = S_BUSY;
                        nxt_op = lnk.cmd;
                        nxt_addr = lnk.cmd_addr;
                        nxt_data = lnk.cmd_data;
                        nxt_cnt = 16'(BUSY_CYC);
                    end else begin
                        // unknown code: no array cycle, ram stays free, mode stays open
                        nxt_fail = sat_inc(fail_ff);
                    end
                end
            end
            S_BUSY: begin
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_last(cnt_ff)) begin
                    nxt_st = S_MODE;
                    nxt_done = 1'b1;
                end
            end
            default: nxt_st = S_NORM;
        endcase
        if (lnk.bit_test) nxt_perr = 1'b0;
        // a fault in the same cycle as the bit test wins over the clear
        if (st_ff == S_NORM && lnk.enter_req && !(lnk.irq_mask_all && lnk.irq_di)) nxt_perr = 1'b1;
        // hold irqs during mode, ack once back in normal mode; set wins over ack
        nxt_ack = !in_mode(st_ff) && irq_pend_ff;
        nxt_irq_pend = (irq_pend_ff && !nxt_ack) || lnk.irq_raw;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // reset mid-command drops it before its commit, so the array keeps its old bytes
            st_ff <= S_NORM;
            cnt_ff <= 16'h0000;
            rel_ff <= 1'b0;
            perr_ff <= 1'b0;
            irq_pend_ff <= 1'b0;
            ack_ff <= 1'b0;
            done_ff <= 1'b0;
            op_ff <= fsp_pkg::FSP_CMD_WRITE;
            addr_ff <= fsp_pkg::ZERO_BYTE;
            data_ff <= fsp_pkg::ZERO_BYTE;
            fail_ff <= fsp_pkg::ZERO_BYTE;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rel_ff <= nxt_rel;
            perr_ff <= nxt_perr;
            irq_pend_ff <= nxt_irq_pend;
            ack_ff <= nxt_ack;
            done_ff <= nxt_done;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            fail_ff <= nxt_fail;
        end
    end

    // ==========================================================
    // flash array: commit on the last busy cycle only
    genvar gi;
    generate
        for (gi = 0; gi < BLK_BYTES * NBLK; gi++) begin : g_cell
            always_ff @(posedge mclk) begin
                if (st_ff == S_BUSY && cnt_last(cnt_ff)) begin
                    if (op_ff == fsp_pkg::FSP_CMD_ERASE && blk_of(gi) == blk_of(int'(addr_ff[AW-1:0]))) begin
                        mem[gi] <= fsp_pkg::BLANK_BYTE;
                    end else if (op_ff == fsp_pkg::FSP_CMD_WRITE && gi == int'(addr_ff[AW-1:0])) begin
                        // a write only clears bits; setting them back takes an erase
                        mem[gi] <= mem[gi] & data_ff;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        rd_data_ff <= mem[rd_addr[AW-1:0]];
    end

    // ==========================================================
    // outputs
    // ram locked for the whole busy span, commit cycle included
    assign ram_en = !(st_ff == S_BUSY);
    // refused entries and unknown command codes
    assign cmd_fail_cnt_ff = fail_ff;
    assign lnk.halt_rel = rel_ff;
    assign lnk.busy = (st_ff == S_BUSY);
    assign lnk.done = done_ff;
    assign lnk.mode_on = in_mode(st_ff);
    assign lnk.prot_err = perr_ff;
    assign lnk.irq_ack = ack_ff;
endmodule : fsp_seq

// ### testbench/fsp_checker.sv
// link checker for the core end and sequencer pair
// assumes the bench instantiates it beside the link
`timescale 1ns/100ps
module fsp_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link
    input wire logic enter_req,
    input wire logic halt_req,
    input wire logic halt_rel,
    input wire logic cmd_valid,
    input wire logic busy,
    input wire logic done,
    input wire logic mode_on,
    input wire logic irq_ack,
    input wire logic irq_mask_all,
    input wire logic irq_di
);
    // worst case release, 10 us plus two clocks
    localparam int REL_MAX = 1002;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // cycles spent in halt with no release yet; a counter, as the bound is too long for a delay range
    logic [15:0] halt_wait_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) halt_wait_ff <= 16'h0000;
        else if (halt_req && !halt_rel) halt_wait_ff <= halt_wait_ff + 16'h0001;
        else halt_wait_ff <= 16'h0000;
    end
    // ==========================================
    // link rules
    irq_defer_a: assert property (irq_ack |-> !mode_on) else $error("irq acked in mode");
    ack_pulse_a: assert property (irq_ack |=> !irq_ack) else $error("ack too long");
    enter_mask_a: assert property (enter_req |-> irq_mask_all && irq_di) else $error("entry unmasked");
    rel_bound_a: assert property (halt_wait_ff <= 16'(REL_MAX)) else $error("no release");
    rel_mode_a: assert property (halt_rel |-> mode_on) else $error("release out of mode");
    rel_pulse_a: assert property (halt_rel |=> !halt_rel) else $error("release too long");
    cmd_mode_a: assert property (cmd_valid |-> mode_on) else $error("cmd out of mode");
    done_bound_a: assert property ($rose(busy) |-> ##[1:64] done) else $error("cmd never done");
    done_cause_a: assert property (done |-> $past(busy)) else $error("done without busy");
endmodule : fsp_checker

// ### testbench/flash_self_program_control_bench.sv
// bench for the core end and sequencer joined by the link
// assumes short counts: ready 4, busy 4, osc wait 8
`timescale 1ns/100ps
module flash_self_program_control_bench;
    logic mclk, rst_n, usr_enter, usr_osc_clk, usr_clk_ok, usr_cmd_valid, usr_irq, usr_err_check;
    logic usr_ready, usr_in_mode, usr_err_ff, usr_irq_taken, ram_en, ram_bad, bit_seen;
    fsp_pkg::fsp_cmd_t usr_cmd;
    logic [7:0] usr_addr, usr_data, rd_addr, rd_data, fail_cnt;
    int errors = 0;
    int cmp_count = 0;
    fsp_if lnk ();
    fsp_core_end #(.OSC_WAIT(8)) i_fsp_core_end (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
        .usr_enter(usr_enter), .usr_osc_clk(usr_osc_clk), .usr_clk_ok(usr_clk_ok),
        .usr_cmd_valid(usr_cmd_valid), .usr_cmd(usr_cmd), .usr_addr(usr_addr), .usr_data(usr_data),
        .usr_irq(usr_irq), .usr_err_check(usr_err_check), .usr_ready(usr_ready),
        .usr_in_mode(usr_in_mode), .usr_err_ff(usr_err_ff), .usr_irq_taken(usr_irq_taken));
    fsp_seq #(.READY_CYC(4), .BUSY_CYC(4)) i_fsp_seq (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
        .rd_addr(rd_addr), .rd_data_ff(rd_data), .ram_en(ram_en), .cmd_fail_cnt_ff(fail_cnt));
    fsp_checker i_fsp_checker (.mclk(mclk), .rst_n(rst_n), .enter_req(lnk.enter_req),
        .halt_req(lnk.halt_req), .halt_rel(lnk.halt_rel), .cmd_valid(lnk.cmd_valid), .busy(lnk.busy),
        .done(lnk.done), .mode_on(lnk.mode_on), .irq_ack(lnk.irq_ack), .irq_mask_all(lnk.irq_mask_all),
        .irq_di(lnk.irq_di));
    // ==========================================
    // common tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // one command, waits for done; ram must stay locked while busy
    task do_cmd(input fsp_pkg::fsp_cmd_t c, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (usr_ready !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
        usr_cmd = c;
        usr_addr = a;
        usr_data = d;
        usr_cmd_valid = 1'b1;
        @(negedge mclk) usr_cmd_valid = 1'b0;
        n = 0;
        // exit has no done pulse; it is finished once the mode flag drops
        while (n < 200 && (c == fsp_pkg::FSP_CMD_EXIT ? lnk.mode_on !== 1'b0 : lnk.done !== 1'b1)) begin
            if (lnk.busy === 1'b1 && ram_en !== 1'b0) ram_bad = 1'b1;
            @(negedge mclk);
            n++;
        end
        chk(8'(n < 200), 8'h01);
        chk(8'(ram_bad), 8'h00);
    endtask : do_cmd
    task rd(input logic [7:0] a, input logic [7:0] exp);
        rd_addr = a;
        @(negedge mclk);
        @(negedge mclk) chk(rd_data, exp);
    endtask : rd
    // ==========================================
    // scenarios
    task t_enter(input logic osc);
        int n;
        usr_osc_clk = osc;
        usr_enter = 1'b1;
        @(negedge mclk) usr_enter = 1'b0;
        n = 0;
        while (lnk.halt_rel !== 1'b1 && n < 1100) begin @(negedge mclk); n++; end
        chk(8'(n < 1100), 8'h01);
        n = 0;
        while (usr_ready !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
        if (osc) chk(8'(n >= 8 && n < 100), 8'h01);
        else chk(8'(n <= 2), 8'h01);
        chk(8'(usr_in_mode), 8'h01);
    endtask : t_enter
    // irq raised in mode must wait for exit
    task t_irq_exit;
        int n;
        usr_irq = 1'b1;
        @(negedge mclk) usr_irq = 1'b0;
        do_cmd(fsp_pkg::FSP_CMD_WRITE, 8'h35, 8'h5a);
        rd(8'h35, 8'h5a);
        chk(8'(usr_irq_taken), 8'h00);
        do_cmd(fsp_pkg::FSP_CMD_EXIT, 8'h00, 8'h00);
        n = 0;
        while (usr_irq_taken !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
        chk(8'(n < 50), 8'h01);
        chk(8'(usr_in_mode), 8'h00);
    endtask : t_irq_exit
    // unknown command code: refused and counted, no array cycle, mode stays open
    task t_bad_cmd;
        int n;
        n = 0;
        while (usr_ready !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
        usr_cmd = fsp_pkg::fsp_cmd_t'(2'h3);
        usr_cmd_valid = 1'b1;
        @(negedge mclk) usr_cmd_valid = 1'b0;
        chk(8'(lnk.busy), 8'h00);
        chk(8'(ram_en), 8'h01);
        chk(fail_cnt, 8'h01);
        chk(8'(usr_in_mode), 8'h01);
    endtask : t_bad_cmd
    // reset during an array cycle: the link must come back idle
    task t_reset_mid;
        int n;
        n = 0;
        while (usr_ready !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
        usr_cmd = fsp_pkg::FSP_CMD_WRITE;
        usr_addr = 8'h40;
        usr_data = 8'h00;
        usr_cmd_valid = 1'b1;
        @(negedge mclk) usr_cmd_valid = 1'b0;
        chk(8'(lnk.busy), 8'h01);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        chk(8'(lnk.busy), 8'h00);
        chk(8'(usr_in_mode), 8'h00);
        chk(8'(usr_ready), 8'h00);
    endtask : t_reset_mid
    task t_err_bit;
        bit_seen = 1'b0;
        usr_err_check = 1'b1;
        // bit_test follows the request combinationally; look while it stands
        @(posedge mclk) if (lnk.bit_test === 1'b1) bit_seen = 1'b1;
        @(negedge mclk) usr_err_check = 1'b0;
        chk(8'(bit_seen), 8'h01);
        chk(8'(usr_err_ff), 8'h00);
    endtask : t_err_bit
    // ==========================================
    // clock, reset, sequence, watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {usr_enter, usr_cmd_valid, usr_irq, usr_err_check, ram_bad} = '0;
        {usr_osc_clk, usr_clk_ok} = 2'b11;
        usr_cmd = fsp_pkg::FSP_CMD_WRITE;
        {usr_addr, usr_data, rd_addr} = '0;
        rst_n = 1'b0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        t_enter(1'b1);
        do_cmd(fsp_pkg::FSP_CMD_ERASE, 8'h30, 8'h00);
        for (int i = 0; i < 16; i++) rd(8'h30 + 8'(i), 8'hff);
        t_bad_cmd();
        t_irq_exit();
        t_enter(1'b0);
        t_reset_mid();
        t_err_bit();
        tally_and_finish();
    end
    // whole run needs under 3000 cycles
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule : flash_self_program_control_bench
